//--- src/wr_port_params.svh
// Constants shared by the write port and its beat buffer.
`ifndef WR_PORT_PARAMS_SVH
`define WR_PORT_PARAMS_SVH

// ==========================================================
// Fixed field widths of the address channel
// ==========================================================
`define WRP_ADDR_W        32
`define WRP_LEN_W         8
`define WRP_SIZE_W        2
`define WRP_BURST_W       2

// ==========================================================
// Build-time defaults and legal limits
// ==========================================================
`define WRP_ID_W_DEF      6
`define WRP_ID_W_MAX      6
`define WRP_USER_W_DEF    4
`define WRP_USER_W_MAX    4
`define WRP_DATA_W_DEF    32
`define WRP_DATA_W_NARROW 32
`define WRP_DATA_W_WIDE   64
`define WRP_BYTE_W        8
`define WRP_FIFO_DEPTH    8

`endif

//--- src/wr_port_pkg.sv
// Types shared by the write port modules.
package wr_port_pkg;

    // ======================================================
    // Burst sequencer states
    // ======================================================
    typedef enum logic {
        ST_IDLE,
        ST_BURST
    } wr_state_t;

endpackage : wr_port_pkg

//--- src/beat_if.sv
// Valid/ready carrier for one word between the port's own modules.
`timescale 1ns/1ps

interface beat_if #(
    parameter int W = 8
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : beat_if

//--- src/beat_fifo.sv
// Flip-flop FIFO that buffers write data beats ahead of the bus.
`timescale 1ns/1ps

`include "wr_port_params.svh"

module beat_fifo
    import wr_port_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = `WRP_FIFO_DEPTH
) (
    // Clock, reset and freeze.
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic ce,
    // Filling and draining sides.
    beat_if.snk       in_if,
    beat_if.src       out_if
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

    // ======================================================
    // Elaboration checks
    // ======================================================
    // Pointers wrap by overflow, so the depth must be a power of two.
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
        $error("beat_fifo depth must be a power of two of 2 or more");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr;
        logic [PW-1:0]               rd;
        logic [PW:0]                 cnt;
    } fifo_st_t;

    fifo_st_t s_q;
    fifo_st_t s_d;
    logic     push;
    logic     pop;

    // ======================================================
    // Handshakes
    // ======================================================
    // Ready drops while frozen so that no word is taken unseen.
    assign in_if.ready  = ce && (s_q.cnt != FULL_CNT);
    assign out_if.valid = (s_q.cnt != '0);
    assign out_if.data  = s_q.mem[s_q.rd];
    assign push = in_if.valid && in_if.ready;
    assign pop  = out_if.valid && out_if.ready && ce;

    // Next state of pointers, count and storage.
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = in_if.data;
            s_d.wr = s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = s_q.rd + 1'b1;
        end
        if (push && !pop) begin
            s_d.cnt = s_q.cnt + 1'b1;
        end else if (pop && !push) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
    end

    // State register; reset is sampled on the clock edge.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // ======================================================
    // Checks
    // ======================================================
    a_fifo_no_overrun: assert property (@(posedge ref_clk)
        disable iff (!rst_n) s_q.cnt <= FULL_CNT)
        else $error("FIFO count exceeds depth");

    c_fifo_full: cover property (@(posedge ref_clk)
        disable iff (!rst_n) s_q.cnt == FULL_CNT);

endmodule : beat_fifo

//--- src/axi_wr_port.sv
// Write address and write data channels of a burst master port.
//
// What this block does
// - Drive a tag of 1 to 6 bits
// - Address names only the first beat
// - Length field fixes beats per address
// - Size field gives bytes per beat
// - Burst type shapes later beat addresses
// - Address valid high only with command
// - Hold address fields until ready seen
// - User sideband of 1 to 4 bits
// - Data bus is 32 or 64 bits
// - One strobe per data byte lane
// - Last marks only the final beat
// - Data valid with data; slave readies
// - Active low reset sampled on clock
`timescale 1ns/1ps

`include "wr_port_params.svh"

module axi_wr_port
    import wr_port_pkg::*;
#(
    parameter int transaction_tag_width_param = `WRP_ID_W_DEF,
    parameter int DATA_W     = `WRP_DATA_W_DEF,
    parameter int USER_W     = `WRP_USER_W_DEF,
    parameter int FIFO_DEPTH = `WRP_FIFO_DEPTH
) (
    // Clock, reset and freeze.
    input  wire logic                     ref_clk,
    input  wire logic                     rst_n,
    input  wire logic                     ce,
    // Burst commands from the core.
    input  wire logic                     cmd_valid,
    output wire logic                     cmd_ready,
    input  wire logic [transaction_tag_width_param-1:0] cmd_id,
    input  wire logic [`WRP_ADDR_W-1:0]   cmd_addr,
    input  wire logic [`WRP_LEN_W-1:0]    cmd_len,
    input  wire logic [`WRP_SIZE_W-1:0]   cmd_size,
    input  wire logic [`WRP_BURST_W-1:0]  cmd_burst,
    // Data beats from the core.
    input  wire logic                     beat_valid,
    output wire logic                     beat_ready,
    input  wire logic [DATA_W-1:0]        beat_data,
    input  wire logic [DATA_W/`WRP_BYTE_W-1:0] beat_strb,
    input  wire logic [USER_W-1:0]        beat_user,
    // Write address channel.
    output wire logic [transaction_tag_width_param-1:0] m_axi_awid,
    output wire logic [`WRP_ADDR_W-1:0]   m_axi_awaddr,
    output wire logic [`WRP_LEN_W-1:0]    m_axi_awlen,
    output wire logic [`WRP_SIZE_W-1:0]   m_axi_awsize,
    output wire logic [`WRP_BURST_W-1:0]  m_axi_awburst,
    output wire logic                     m_axi_awvalid,
    input  wire logic                     m_axi_awready,
    // Write data channel.
    output wire logic [USER_W-1:0]        m_axi_wuser,
    output wire logic [DATA_W-1:0]        m_axi_wdata,
    output wire logic [DATA_W/`WRP_BYTE_W-1:0] m_axi_wstrb,
    output wire logic                     m_axi_wlast,
    output wire logic                     m_axi_wvalid,
    input  wire logic                     m_axi_wready
);
    localparam int IDW = transaction_tag_width_param;
    localparam int SW  = DATA_W / `WRP_BYTE_W;
    localparam int FW  = USER_W + SW + DATA_W;

    // ======================================================
    // Elaboration checks
    // ======================================================
    // Tag width range.
    if (IDW < 1 || IDW > `WRP_ID_W_MAX) begin : g_bad_id
        $error("tag width must be 1 to 6 bits");
    end
    if (USER_W < 1 || USER_W > `WRP_USER_W_MAX) begin : g_bad_user
        $error("user width must be 1 to 4 bits");
    end
    if (DATA_W != `WRP_DATA_W_NARROW && DATA_W != `WRP_DATA_W_WIDE)
    begin : g_bad_data
        $error("data width must be 32 or 64 bits");
    end

    // ======================================================
    // State
    // ======================================================
    typedef struct packed {
        wr_state_t                st;
        logic [IDW-1:0]           id;
        logic [`WRP_ADDR_W-1:0]   addr;
        logic [`WRP_LEN_W-1:0]    len;
        logic [`WRP_SIZE_W-1:0]   size;
        logic [`WRP_BURST_W-1:0]  burst;
        logic                     aw_pend;
        logic                     w_pend;
        logic [`WRP_LEN_W-1:0]    beats;
    } port_st_t;

    port_st_t s_q;
    port_st_t s_d;

    logic cmd_take;
    logic aw_take;
    logic w_take;
    logic last_beat;

    // ======================================================
    // Beat buffer
    // ======================================================
    beat_if #(.W(FW)) fill_if ();
    beat_if #(.W(FW)) drain_if ();

    // Strobe lane n travels with data bits 8n to 8n+7.
    assign fill_if.valid = beat_valid;
    assign fill_if.data  = {beat_user, beat_strb, beat_data};
    assign beat_ready    = fill_if.ready;

    beat_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .in_if   (fill_if),
        .out_if  (drain_if)
    );

    // ======================================================
    // Handshakes
    // ======================================================
    // A new command is taken only between bursts; this keeps one
    // burst's beats together and makes the last beat easy to find.
    assign cmd_ready = ce && (s_q.st == ST_IDLE);
    assign cmd_take  = cmd_valid && cmd_ready;
    // Transfers count only with valid and ready both high.
    assign aw_take   = m_axi_awvalid && m_axi_awready && ce;
    assign w_take    = m_axi_wvalid && m_axi_wready && ce;
    assign last_beat = (s_q.beats == '0);

    // Data valid only while a burst owns buffered data.
    assign m_axi_wvalid   = s_q.w_pend && drain_if.valid;
    assign drain_if.ready = s_q.w_pend && m_axi_wready;

    // Address channel driven straight from held command fields.
    assign m_axi_awid    = s_q.id;
    assign m_axi_awaddr  = s_q.addr;
    assign m_axi_awlen   = s_q.len;
    assign m_axi_awsize  = s_q.size;
    assign m_axi_awburst = s_q.burst;
    // Address valid follows the pending command.
    assign m_axi_awvalid = s_q.aw_pend;

    // Sideband, strobes and data leave the buffer flops.
    assign m_axi_wdata = drain_if.data[DATA_W-1:0];
    assign m_axi_wstrb = drain_if.data[DATA_W +: SW];
    assign m_axi_wuser = drain_if.data[DATA_W+SW +: USER_W];
    // Last only when no beats remain after this one.
    assign m_axi_wlast = s_q.w_pend && last_beat;

    // ======================================================
    // Burst sequencer
    // ======================================================
    // Next state; the address and data halves retire on their own.
    always_comb begin
        s_d = s_q;
        case (s_q.st)
            ST_IDLE: begin
                if (cmd_take) begin
                    s_d.id      = cmd_id;
                    s_d.addr    = cmd_addr;
                    s_d.len     = cmd_len;
                    s_d.size    = cmd_size;
                    s_d.burst   = cmd_burst;
                    s_d.aw_pend = 1'b1;
                    s_d.w_pend  = 1'b1;
                    // Beat count taken from the length field.
                    s_d.beats   = cmd_len;
                    s_d.st      = ST_BURST;
                end
            end
            ST_BURST: begin
                // Fields stay put; only ready retires them.
                if (aw_take) begin
                    s_d.aw_pend = 1'b0;
                end
                if (w_take) begin
                    if (last_beat) begin
                        s_d.w_pend = 1'b0;
                    end else begin
                        s_d.beats = s_q.beats - 1'b1;
                    end
                end
                if (!s_d.aw_pend && !s_d.w_pend) begin
                    s_d.st = ST_IDLE;
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
    end

    // Reset is active low and sampled on the clock edge.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // ======================================================
    // Checks
    // ======================================================
    // Helper that counts accepted beats of the current burst.
    logic [`WRP_LEN_W:0] chk_cnt_q;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            chk_cnt_q <= '0;
        end else if (w_take) begin
            chk_cnt_q <= m_axi_wlast ? '0 : chk_cnt_q + 1'b1;
        end
    end

    a_aw_idle_low: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        s_q.st == ST_IDLE |-> !m_axi_awvalid)
        else $error("address valid high with no command");

    a_aw_hold_fields: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        m_axi_awvalid && !m_axi_awready |=> m_axi_awvalid
        && $stable(m_axi_awaddr) && $stable(m_axi_awlen)
        && $stable(m_axi_awsize)
        && $stable(m_axi_awid) && $stable(m_axi_awburst))
        else $error("address fields changed before ready");

    a_tag_forward: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        cmd_take |=> m_axi_awvalid && m_axi_awid == $past(cmd_id))
        else $error("tag not presented with address");

    a_addr_forward: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        cmd_take |=> m_axi_awaddr == $past(cmd_addr))
        else $error("start address not presented");

    a_ctrl_forward: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        cmd_take |=> m_axi_awsize == $past(cmd_size)
        && m_axi_awburst == $past(cmd_burst))
        else $error("size or type not presented");

    a_len_beats: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        w_take && m_axi_wlast |-> chk_cnt_q == {1'b0, s_q.len})
        else $error("beat count differs from length");

    a_last_final: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        w_take && chk_cnt_q == {1'b0, s_q.len} |-> m_axi_wlast)
        else $error("last missing on final beat");

    a_w_hold_data: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        m_axi_wvalid && !m_axi_wready && ce |=> m_axi_wvalid
        && $stable(m_axi_wdata) && $stable(m_axi_wstrb))
        else $error("data changed before ready");

    a_w_hold_side: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        m_axi_wvalid && !m_axi_wready && ce
        |=> $stable(m_axi_wuser) && $stable(m_axi_wlast))
        else $error("sideband or last changed before ready");

    // Buffered beats must not leak out while no burst owns them.
    a_w_needs_burst: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        s_q.st == ST_IDLE |-> !m_axi_wvalid && !m_axi_wlast)
        else $error("data valid with no open burst");

    a_freeze_ready: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        !ce |-> !cmd_ready && !beat_ready)
        else $error("ready high while frozen");

    a_burst_retire: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        s_q.st == ST_BURST && !s_q.w_pend && aw_take
        |=> s_q.st == ST_IDLE)
        else $error("burst did not retire after handshakes");

    c_aw_stall: cover property (@(posedge ref_clk)
        disable iff (!rst_n)
        m_axi_awvalid && !m_axi_awready ##1 aw_take);

    c_long_burst: cover property (@(posedge ref_clk)
        disable iff (!rst_n)
        w_take && m_axi_wlast && s_q.len > 8'h2);

    c_single_beat: cover property (@(posedge ref_clk)
        disable iff (!rst_n)
        w_take && m_axi_wlast && s_q.len == 8'h0);

    c_frozen_wait: cover property (@(posedge ref_clk)
        disable iff (!rst_n)
        !ce && beat_valid);

endmodule : axi_wr_port

//--- verif/wr_slave_model.sv
// Behavioural write slave that records every accepted transfer.
`timescale 1ns/1ps

module wr_slave_model #(
    parameter int IDW = 6,
    parameter int DW  = 32,
    parameter int UW  = 4
) (
    // Clock and pacing controls.
    input  wire logic            ref_clk,
    input  wire logic            slow,
    input  wire logic            hold_w,
    // Write address channel.
    input  wire logic [IDW-1:0]  awid,
    input  wire logic [31:0]     awaddr,
    input  wire logic [7:0]      awlen,
    input  wire logic [1:0]      awsize,
    input  wire logic [1:0]      awburst,
    input  wire logic            awvalid,
    output wire logic            awready,
    // Write data channel.
    input  wire logic [UW-1:0]   wuser,
    input  wire logic [DW-1:0]   wdata,
    input  wire logic [DW/8-1:0] wstrb,
    input  wire logic            wlast,
    input  wire logic            wvalid,
    output wire logic            wready
);
    // ==========================================================
    // Pacing and capture
    // ==========================================================
    logic [1:0]  cnt_q = 2'h0;
    logic [63:0] aw_q[$];
    logic [63:0] w_q[$];

    // ready pacing
    // Slow mode readies the two channels on different phases.
    assign awready = !slow || (cnt_q == 2'h0);
    assign wready  = !hold_w && (!slow || cnt_q[0]);

    // transfer on handshake
    // Only edges with valid and ready both high count as transfers.
    always @(posedge ref_clk) begin
        cnt_q <= cnt_q + 2'h1;
        if (awvalid && awready) begin
            aw_q.push_back(64'({awid, awaddr, awlen, awsize, awburst}));
        end
        if (wvalid && wready) begin
            w_q.push_back(64'({wlast, wuser, wstrb, wdata}));
        end
    end
endmodule : wr_slave_model

//--- verif/tb_top.sv
// Self-checking bench for the burst write port.
`timescale 1ns/1ps

module tb_top;
    // ==========================================================
    // Signals
    // ==========================================================
    logic        ref_clk, rst_n, ce, cmd_valid, beat_valid, slow, hold_w;
    logic        cmd_ready, beat_ready, awvalid, awready;
    logic        wlast, wvalid, wready, awv_p, wv_p;
    logic [5:0]  cmd_id, awid;
    logic [31:0] cmd_addr, awaddr, beat_data, wdata;
    logic [7:0]  cmd_len, awlen;
    logic [1:0]  cmd_size, cmd_burst, awsize, awburst;
    logic [3:0]  beat_strb, beat_user, wstrb, wuser;
    logic [63:0] aw_p, w_p;
    int          err_count, num_checks;

    axi_wr_port dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_id(cmd_id),
        .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_size(cmd_size),
        .cmd_burst(cmd_burst), .beat_valid(beat_valid),
        .beat_ready(beat_ready), .beat_data(beat_data),
        .beat_strb(beat_strb), .beat_user(beat_user),
        .m_axi_awid(awid), .m_axi_awaddr(awaddr), .m_axi_awlen(awlen),
        .m_axi_awsize(awsize), .m_axi_awburst(awburst),
        .m_axi_awvalid(awvalid), .m_axi_awready(awready),
        .m_axi_wuser(wuser), .m_axi_wdata(wdata), .m_axi_wstrb(wstrb),
        .m_axi_wlast(wlast), .m_axi_wvalid(wvalid), .m_axi_wready(wready)
    );

    wr_slave_model slave_u (
        .ref_clk(ref_clk), .slow(slow), .hold_w(hold_w), .awid(awid),
        .awaddr(awaddr), .awlen(awlen), .awsize(awsize),
        .awburst(awburst), .awvalid(awvalid), .awready(awready),
        .wuser(wuser), .wdata(wdata), .wstrb(wstrb), .wlast(wlast),
        .wvalid(wvalid), .wready(wready)
    );

    // 125 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // ==========================================================
    // Checking helpers
    // ==========================================================
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic close_out;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    task automatic timeout;
        err_count++;
        $display("[FAIL] %0t wait ran out", $time);
        close_out();
    endtask : timeout

    // Packed beat as the slave records it: last, user, strobe, data.
    function automatic logic [63:0] wexp(input int n, i, len);
        return 64'({i == len, 4'(n + i), 4'(i + 1), 8'(n), 8'(i), 16'hA55A});
    endfunction : wexp

    function automatic logic [63:0] awexp(input int n, len, sz, bt);
        return 64'({6'(n * 5 + 1), 32'h4000_0000 + 32'(n) * 32'h100,
                    8'(len), 2'(sz), 2'(bt)});
    endfunction : awexp

    // A stalled request must keep every field until it is taken.
    always @(posedge ref_clk) begin
        if (rst_n && awv_p) begin
            chk(64'({awid, awaddr, awlen, awsize, awburst}), aw_p);
        end
        if (rst_n && wv_p) begin
            chk(64'({wlast, wuser, wstrb, wdata}), w_p);
        end
        awv_p <= awvalid && !awready;
        wv_p  <= wvalid && !wready;
        aw_p  <= 64'({awid, awaddr, awlen, awsize, awburst});
        w_p   <= 64'({wlast, wuser, wstrb, wdata});
    end

    // ==========================================================
    // Drivers
    // ==========================================================
    task automatic send_cmd(input int n, len, sz, bt);
        int k;
        @(negedge ref_clk);
        {cmd_id, cmd_addr, cmd_len, cmd_size, cmd_burst} =
            50'(awexp(n, len, sz, bt));
        cmd_valid = 1'b1;
        for (k = 0; k < 300 && cmd_ready !== 1'b1; k++) @(negedge ref_clk);
        if (k == 300) timeout();
        @(posedge ref_clk);
        @(negedge ref_clk);
        cmd_valid = 1'b0;
    endtask : send_cmd

    // Beats go back to back; valid drops only after the last one.
    task automatic push_beats(input int n, first, stop, len);
        int k;
        for (int i = first; i < stop; i++) begin
            @(negedge ref_clk);
            {beat_user, beat_strb, beat_data} = 40'(wexp(n, i, len));
            beat_valid = 1'b1;
            for (k = 0; k < 300 && beat_ready !== 1'b1; k++) begin
                @(negedge ref_clk);
            end
            if (k == 300) timeout();
            @(posedge ref_clk);
        end
        @(negedge ref_clk);
        beat_valid = 1'b0;
    endtask : push_beats

    task automatic check_burst(input int n, len, sz, bt);
        int k;
        for (k = 0; k < 900; k++) begin
            @(negedge ref_clk);
            if (slave_u.w_q.size() >= len + 1 && cmd_ready === 1'b1) break;
        end
        if (k == 900) timeout();
        chk(slave_u.aw_q.size(), 1);
        chk(slave_u.w_q.size(), len + 1);
        chk(slave_u.aw_q.pop_front(), awexp(n, len, sz, bt));
        for (int i = 0; i <= len; i++) begin
            chk(slave_u.w_q.pop_front(), wexp(n, i, len));
        end
    endtask : check_burst

    task automatic run(input int n, len, sz, bt, pre);
        fork
            send_cmd(n, len, sz, bt);
            push_beats(n, pre, len + 1, len);
        join
        check_burst(n, len, sz, bt);
    endtask : run

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic sc_reset;
        @(negedge ref_clk);
        chk({awvalid, wvalid, wlast, cmd_ready, beat_ready}, 5'h03);
    endtask : sc_reset

    // Freezing drops both readies; a stray word would spoil later bursts.
    task automatic sc_freeze;
        @(negedge ref_clk);
        ce = 1'b0;
        beat_valid = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk({cmd_ready, beat_ready}, 2'h0);
        ce = 1'b1;
        beat_valid = 1'b0;
    endtask : sc_freeze

    // Size and burst codes 0 to 2, lengths of 1, 4 and 256 beats.
    task automatic sc_codes;
        for (int n = 0; n < 3; n++) begin
            run(n, (n == 2) ? 255 : n * 3, n, n, 0);
        end
    endtask : sc_codes

    // The slave stalls both channels so the hold monitor gets work.
    task automatic sc_slow;
        slow = 1'b1;
        run(3, 5, 2, 1, 0);
        slow = 1'b0;
    endtask : sc_slow

    // Data arriving before its command must wait in the buffer.
    task automatic sc_early;
        push_beats(4, 0, 2, 1);
        repeat (4) @(negedge ref_clk);
        chk(wvalid, 0);
        run(4, 1, 1, 1, 2);
    endtask : sc_early

    // Fill the buffer against a stalled slave, then drain it.
    task automatic sc_fill;
        hold_w = 1'b1;
        fork
            send_cmd(5, 9, 2, 1);
            push_beats(5, 0, 8, 9);
        join
        @(negedge ref_clk);
        chk(beat_ready, 0);
        chk(wvalid, 1);
        hold_w = 1'b0;
        push_beats(5, 8, 10, 9);
        check_burst(5, 9, 2, 1);
        chk(wvalid, 0);
    endtask : sc_fill

    // Main sequence.
    initial begin
        {rst_n, ce, cmd_valid, beat_valid, slow, hold_w} = 6'h10;
        {cmd_id, cmd_addr, cmd_len, cmd_size, cmd_burst} = 50'h0;
        {beat_data, beat_strb, beat_user} = 40'h0;
        err_count = 0;
        num_checks = 0;
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_n = 1'b1;
        sc_reset();
        sc_freeze();
        sc_codes();
        sc_slow();
        sc_early();
        sc_fill();
        close_out();
    end
endmodule : tb_top
